/* src/rsps_regs.svh */
`ifndef RSPS_REGS_SVH
`define RSPS_REGS_SVH
// address bus goes low 2.5 clocks after the low init level is sampled:
// one rising edge samples it, two more edges follow, then a falling edge
`define RSPS_ADDR_LOW_RISES 2'h2
`define RSPS_ADDR_W 24
`define RSPS_DATA_W 16
`define RSPS_PORT_W 8
`define RSPS_MODE_W 3
`define RSPS_MODE_THREE 3'h3
`define RSPS_MODE_FOUR 3'h4
// init must lead halt by this many clocks for the memory to be kept
`define RSPS_RET_LEAD 4'hA
`endif

/* src/rsps_pkg.sv */
`default_nettype none
`include "rsps_regs.svh"
package rsps_pkg;
  // strobe group, all active low
  typedef struct packed {
    logic as_n;
    logic rd_n;
    logic upper_wr_n;
    logic lower_wr_n;
    logic cs0_n;
  } rsps_strobe_t;
  // one tristate pin group: value and low-active output enable
  typedef struct packed {
    logic [`RSPS_PORT_W-1:0] out;
    logic [`RSPS_PORT_W-1:0] oe_n;
  } rsps_port_t;
  typedef enum logic [1:0] {
    RSPS_RUN = 2'b00,
    RSPS_WAIT = 2'b01,
    RSPS_HELD = 2'b10
  } rsps_state_t;
endpackage
`default_nettype wire

/* src/rsps_addr_timer.sv */
`default_nettype none
`include "rsps_regs.svh"
// counts rising edges after init is first sampled low, then releases
// the address-low request on the following falling edge (half cycle)
module rsps_addr_timer (
  input wire logic clk,
  input wire logic init_sampled,
  input wire logic resetn,
  output var logic addr_low
);
  import rsps_pkg::*;
  rsps_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic fall_q;
  // next-state logic
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RSPS_RUN: begin
        // the second synchroniser stage has already spent one counted edge
        cnt_d = 2'h1;
        if (init_sampled) begin
          if (cnt_q == `RSPS_ADDR_LOW_RISES - 2'h1) begin
            state_d = RSPS_HELD;
          end else begin
            state_d = RSPS_WAIT;
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      RSPS_WAIT: begin
        if (!init_sampled) begin
          state_d = RSPS_RUN;
        end else if (cnt_q == `RSPS_ADDR_LOW_RISES - 2'h1) begin
          state_d = RSPS_HELD;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      RSPS_HELD: begin
        if (!init_sampled) begin
          state_d = RSPS_RUN;
        end
      end
      default: state_d = RSPS_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RSPS_RUN;
      cnt_q <= 2'h1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  // falling-edge stage supplies the extra half cycle
  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= (state_q == RSPS_HELD);
    end
  end
  assign addr_low = fall_q & (state_q == RSPS_HELD);
endmodule // rsps_addr_timer
`default_nettype wire

/* src/rsps_sequencer.sv */
`default_nettype none
`include "rsps_regs.svh"
// Notes on behaviour
// - every general port turns to input at once when init goes low, even mid access.
// - on init low the strobes and chip select zero go high and the data bus floats.
// - the address bus is driven low 2.5 clocks after init is sampled low.
// - the clock output pin turns to output at the first rising edge after init goes low.
// - in modes 3 and 4, upper address and extra select pins float at once on init low.
// - during halt every port, address, data and clock pin floats; the strobes are driven high.
module rsps_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hard_init_in_n,
  input wire logic deep_halt_in_n,
  input wire logic [`RSPS_MODE_W-1:0] mode,
  input wire logic onchip_memory_enable,
  input wire logic upper_addr_used,
  input wire logic extra_cs_used,
  input wire logic bus_active,
  input wire rsps_pkg::rsps_strobe_t core_strobe,
  input wire logic [`RSPS_ADDR_W-1:0] core_addr,
  input wire logic [`RSPS_DATA_W-1:0] core_data_out,
  input wire logic core_data_drive,
  input wire rsps_pkg::rsps_port_t core_port,
  input wire rsps_pkg::rsps_port_t core_upper_pins,
  input wire logic clock_out_value,
  input wire logic clock_out_sel,
  output rsps_pkg::rsps_strobe_t strobe,
  output logic [`RSPS_ADDR_W-1:0] addr_out,
  output logic addr_oe_n,
  output logic [`RSPS_DATA_W-1:0] data_out,
  output logic data_oe_n,
  output rsps_pkg::rsps_port_t port,
  output rsps_pkg::rsps_port_t upper_pins,
  output logic clock_output_pin,
  output logic clock_output_pin_oe_n,
  output logic bus_abort,
  output logic retention_ok
);
  import rsps_pkg::*;

  // synchroniser stages for the clocked paths
  logic init_s1_q, init_s1_d;
  logic init_s2_q, init_s2_d;
  logic halt_s1_q, halt_s1_d;
  logic halt_s2_q, halt_s2_d;
  // raw pin levels and decoded conditions
  logic init_low;
  logic halt_low;
  logic init_sampled;
  logic addr_low;
  logic mode_ext;
  logic upper_float;
  // clock pin direction
  logic clk_oe_q, clk_oe_d;
  // retention watch
  logic seen_init_q, seen_init_d;
  logic [3:0] lead_q, lead_d;
  logic ret_q, ret_d;

  // every output enable of a pin group set to float
  function automatic logic [`RSPS_PORT_W-1:0] float_all();
    float_all = {`RSPS_PORT_W{1'b1}};
  endfunction

  // modes that may put address or select lines on the upper pin group
  function automatic logic is_ext_mode(input logic [`RSPS_MODE_W-1:0] m);
    is_ext_mode = (m == `RSPS_MODE_THREE) || (m == `RSPS_MODE_FOUR);
  endfunction

  // lead counter step; saturates so a very long init never wraps to a short lead
  function automatic logic [3:0] lead_step(input logic [3:0] v);
    lead_step = (v == 4'hF) ? v : v + 4'h1;
  endfunction

  // asynchronous view: pins react the moment init or halt goes low, no edge needed
  assign init_low = !hard_init_in_n;
  assign halt_low = !deep_halt_in_n;
  assign mode_ext = is_ext_mode(mode);
  // on init the upper group floats only when it really carries address or select lines
  assign upper_float = mode_ext && (upper_addr_used || extra_cs_used);

  // synchroniser next values; only the second stage feeds other logic
  always_comb begin
    init_s1_d = init_low;
    init_s2_d = init_s1_q;
    halt_s1_d = halt_low;
    halt_s2_d = halt_s1_q;
  end

  // two-flop synchronisers for the clocked paths
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_s1_q <= 1'b0;
      init_s2_q <= 1'b0;
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
    end else begin
      init_s1_q <= init_s1_d;
      init_s2_q <= init_s2_d;
      halt_s1_q <= halt_s1_d;
      halt_s2_q <= halt_s2_d;
    end
  end
  assign init_sampled = init_s2_q;

  // address timer: counts edges of the sampled init level, then adds a half cycle
  rsps_addr_timer u_timer (
    .clk(clk),
    .init_sampled(init_sampled),
    .resetn(resetn),
    .addr_low(addr_low)
  );

  // clock pin direction; the raw level is used so it turns at the very next rise
  always_comb begin
    clk_oe_d = clk_oe_q;
    if (init_low) begin
      clk_oe_d = 1'b1;
    end else if (!clock_out_sel) begin
      clk_oe_d = 1'b0;
    end
  end

  // clock pin direction register; input after reset until init turns it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_oe_q <= 1'b0;
    end else begin
      clk_oe_q <= clk_oe_d;
    end
  end

  // retention watch: both lines pass the same two stages, so the lead is exact
  always_comb begin
    lead_d = lead_q;
    seen_init_d = seen_init_q;
    ret_d = ret_q;
    if (!init_sampled) begin
      lead_d = 4'h0;
    end else begin
      lead_d = lead_step(lead_q);
    end
    if (halt_s2_q && !seen_init_q) begin
      seen_init_d = 1'b1;
      // memory kept only if init led by enough clocks, or retention was off
      ret_d = !onchip_memory_enable || (lead_q >= `RSPS_RET_LEAD);
    end else if (!halt_s2_q) begin
      seen_init_d = 1'b0;
    end
  end

  // retention registers; the flag starts true so a fresh part reports no loss
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lead_q <= 4'h0;
      seen_init_q <= 1'b0;
      ret_q <= 1'b1;
    end else begin
      lead_q <= lead_d;
      seen_init_q <= seen_init_d;
      ret_q <= ret_d;
    end
  end

  assign retention_ok = ret_q;
  // abort only matters while the core is really out on the bus
  assign bus_abort = init_low & bus_active;

  // strobes and data bus: strobes high and data floating on init or halt
  always_comb begin
    strobe = core_strobe;
    data_out = core_data_out;
    data_oe_n = !core_data_drive;
    if (init_low) begin
      strobe = '1;
      data_oe_n = 1'b1;
    end
    if (halt_low) begin
      strobe = '1;
      data_oe_n = 1'b1;
    end
  end

  // address bus: held until the timer fires, then low, floated in halt
  always_comb begin
    addr_out = core_addr;
    addr_oe_n = 1'b0;
    if (init_low && addr_low) begin
      addr_out = '0;
    end
    if (halt_low) begin
      addr_oe_n = 1'b1;
    end
  end

  // general pin group inputs at once on init, upper group too when upper_float; both floated in halt
  always_comb begin
    port = core_port;
    upper_pins = core_upper_pins;
    if (init_low) begin
      port.oe_n = float_all();
      if (upper_float) begin
        upper_pins.oe_n = float_all();
      end
    end
    if (halt_low) begin
      port.oe_n = float_all();
      upper_pins.oe_n = float_all();
    end
  end

  // clock pin: value passes through, direction from its register, floated in halt
  always_comb begin
    clock_output_pin = clock_out_value;
    clock_output_pin_oe_n = !clk_oe_q;
    if (halt_low) begin
      clock_output_pin_oe_n = 1'b1;
    end
  end
endmodule // rsps_sequencer
`default_nettype wire

/* sim/rsps_chk_asserts.sv */
`default_nettype none
`include "rsps_regs.svh"
module rsps_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hard_init_in_n,
  input wire logic deep_halt_in_n,
  input wire logic [`RSPS_MODE_W-1:0] mode,
  input wire logic upper_addr_used,
  input wire logic extra_cs_used,
  input wire logic bus_active,
  input wire rsps_pkg::rsps_strobe_t strobe,
  input wire logic [`RSPS_ADDR_W-1:0] addr_out,
  input wire logic addr_oe_n,
  input wire logic data_oe_n,
  input wire rsps_pkg::rsps_port_t port,
  input wire rsps_pkg::rsps_port_t upper_pins,
  input wire logic clock_output_pin_oe_n,
  input wire logic bus_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // halt overrides init, so the strobe, address and clock init checks are taken outside halt
  a_port_input: assert property (!hard_init_in_n |-> port.oe_n == 8'hFF)
    else $error("ports not input under init");
  a_strobe_idle: assert property (!hard_init_in_n && deep_halt_in_n |->
    strobe == 5'h1F && data_oe_n) else $error("strobes or data bus wrong under init");
  a_addr_low: assert property ((!hard_init_in_n && deep_halt_in_n) [*5] |->
    addr_out == 24'h0) else $error("address not low after init");
  a_clock_oe: assert property ($fell(hard_init_in_n) && deep_halt_in_n |=>
    !clock_output_pin_oe_n) else $error("clock pin not output after init");
  a_upper_float: assert property (!hard_init_in_n && (upper_addr_used || extra_cs_used) &&
    (mode == 3'h3 || mode == 3'h4) |-> upper_pins.oe_n == 8'hFF)
    else $error("upper pins driven under init");
  a_halt_float: assert property (!deep_halt_in_n |-> addr_oe_n && data_oe_n &&
    &port.oe_n && &upper_pins.oe_n) else $error("pins driven during halt");
  a_abort_now: assert property (bus_abort == (!hard_init_in_n && bus_active))
    else $error("bus abort wrong");
  c_init_access: cover property ($fell(hard_init_in_n) && bus_active);
  c_halt: cover property ($fell(deep_halt_in_n));
  c_halt_plain: cover property ($fell(deep_halt_in_n) && hard_init_in_n);
  c_mode_four: cover property (!hard_init_in_n && mode == 3'h4);
endmodule // rsps_chk
`default_nettype wire

/* sim/rsps_ext_ctl.sv */
`default_nettype none
module rsps_ext_ctl (
  input wire logic clk,
  output logic init_n,
  output logic halt_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // both lines idle high until a task moves them
  initial begin
    init_n = 1'b1;
    halt_n = 1'b1;
  end
  task automatic set_init(input logic v);
    init_n <= v;
  endtask
  // a short lead is asked for on purpose to see the retention flag drop
  task automatic enter(input logic retain, input int lead);
    if (retain) init_n <= 1'b0;
    repeat (lead) @(posedge clk);
    halt_n <= 1'b0;
    @(posedge clk);
    init_n <= 1'b1;
  endtask
  // ten clocks at 100 MHz give the lead before halt lifts
  task automatic leave();
    init_n <= 1'b0;
    repeat (10) @(posedge clk);
    halt_n <= 1'b1;
    @(posedge clk);
    init_n <= 1'b1;
  endtask
endmodule // rsps_ext_ctl
`default_nettype wire

/* sim/rsps_sequencer_bench.sv */
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module rsps_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsps_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, hard_init_in_n, deep_halt_in_n;
  logic [2:0] mode = 3'h1;
  logic onchip_memory_enable = 1'b1, upper_addr_used = 1'b1, extra_cs_used = 1'b0;
  logic bus_active = 1'b1, core_data_drive = 1'b1, clock_out_value = 1'b0, clock_out_sel = 1'b1;
  rsps_strobe_t core_strobe = 5'h00, strobe;
  logic [23:0] core_addr = 24'h123456, addr_out;
  logic [15:0] core_data_out = 16'hA5A5, data_out;
  rsps_port_t core_port = 16'h0000, core_upper_pins = 16'h0000, port, upper_pins;
  logic addr_oe_n, data_oe_n, clock_output_pin, clock_output_pin_oe_n, bus_abort, retention_ok;
  int err_count = 0, compares = 0;
  rsps_sequencer uut (
    .clk(clk),
    .resetn(resetn),
    .hard_init_in_n(hard_init_in_n),
    .deep_halt_in_n(deep_halt_in_n),
    .mode(mode),
    .onchip_memory_enable(onchip_memory_enable),
    .upper_addr_used(upper_addr_used),
    .extra_cs_used(extra_cs_used),
    .bus_active(bus_active),
    .core_strobe(core_strobe),
    .core_addr(core_addr),
    .core_data_out(core_data_out),
    .core_data_drive(core_data_drive),
    .core_port(core_port),
    .core_upper_pins(core_upper_pins),
    .clock_out_value(clock_out_value),
    .clock_out_sel(clock_out_sel),
    .strobe(strobe),
    .addr_out(addr_out),
    .addr_oe_n(addr_oe_n),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .port(port),
    .upper_pins(upper_pins),
    .clock_output_pin(clock_output_pin),
    .clock_output_pin_oe_n(clock_output_pin_oe_n),
    .bus_abort(bus_abort),
    .retention_ok(retention_ok)
  );
  rsps_ext_ctl ext (.clk(clk), .init_n(hard_init_in_n), .halt_n(deep_halt_in_n));
  always #5 clk = ~clk;
  task automatic close_out();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // init drops mid access; checks a ns later show no clock edge was needed
  task automatic t_init(input logic [2:0] m);
    mode <= m;
    extra_cs_used <= m[0];
    upper_addr_used <= !m[0];
    // park the clock pin as input first so its turn on init can be seen
    clock_out_sel <= 1'b0;
    @(posedge clk); #1;
    `CHK({strobe, data_oe_n}, 6'h00)
    `CHK({data_out, clock_output_pin}, {16'hA5A5, 1'b0})
    @(posedge clk);
    clock_out_sel <= 1'b1;
    ext.set_init(1'b0);
    #1;
    `CHK(port.oe_n, 8'hFF)
    `CHK({strobe, data_oe_n}, 6'h3F)
    `CHK(bus_abort, 1'b1)
    `CHK(clock_output_pin_oe_n, 1'b1)
    if (m >= 3'h3) `CHK(upper_pins.oe_n, 8'hFF)
    else `CHK(upper_pins.oe_n, 8'h00)
    @(posedge clk); #1;
    `CHK(clock_output_pin_oe_n, 1'b0)
    repeat (2) @(posedge clk); #1;
    `CHK(addr_out, core_addr)
    @(posedge clk); #1;
    `CHK(addr_out, 24'h0)
    @(posedge clk);
    ext.set_init(1'b1);
    repeat (4) @(posedge clk);
    $display("test init mode %0d done", m);
  endtask
  // halt entry with or without retention; with retention the lead decides the flag
  task automatic t_halt(input logic keep, input int lead, input logic exp);
    @(posedge clk);
    onchip_memory_enable <= keep;
    ext.enter(keep, lead);
    #1;
    `CHK({addr_oe_n, data_oe_n, port.oe_n, upper_pins.oe_n}, 18'h3FFFF)
    `CHK({strobe, clock_output_pin_oe_n}, 6'h3F)
    @(posedge clk);
    ext.leave();
    @(posedge clk); #1;
    `CHK(retention_ok, exp)
    $display("test halt keep %0d lead %0d done", keep, lead);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int m = 1; m <= 4; m++) t_init(m[2:0]);
    t_halt(1'b1, 10, 1'b1);
    t_halt(1'b1, 2, 1'b0);
    t_halt(1'b0, 0, 1'b1);
    close_out();
  end
endmodule // rsps_sequencer_bench
bind rsps_sequencer rsps_chk chk (
  .clk(clk),
  .resetn(resetn),
  .hard_init_in_n(hard_init_in_n),
  .deep_halt_in_n(deep_halt_in_n),
  .mode(mode),
  .upper_addr_used(upper_addr_used),
  .extra_cs_used(extra_cs_used),
  .bus_active(bus_active),
  .strobe(strobe),
  .addr_out(addr_out),
  .addr_oe_n(addr_oe_n),
  .data_oe_n(data_oe_n),
  .port(port),
  .upper_pins(upper_pins),
  .clock_output_pin_oe_n(clock_output_pin_oe_n),
  .bus_abort(bus_abort)
);
`default_nettype wire
